// [common/valve_map_pkg.sv]
// Package: valve network map constants, field layouts and carrier types
package valve_map_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int unsigned NUM_VALVES  = 250;
   localparam logic [7:0]  VALVE_LAST  = 8'(NUM_VALVES - 1);
   localparam logic [15:0] VALVE_COUNT = 16'(NUM_VALVES);
   localparam logic [15:0] DI_COUNT    = 16'h0FA0;
   localparam logic [15:0] COIL_COUNT  = 16'h03E8;
   localparam logic [15:0] CMD_WORDS   = 16'h003F;

   // ---------------------------------------------------------------
   // Function codes
   // ---------------------------------------------------------------
   localparam logic [7:0] FC_READ_DISCRETE = 8'h02;
   localparam logic [7:0] FC_READ_HOLDING  = 8'h03;
   localparam logic [7:0] FC_READ_INPUT    = 8'h04;
   localparam logic [7:0] FC_WRITE_COIL    = 8'h05;
   localparam logic [7:0] FC_WRITE_REG     = 8'h06;
   localparam logic [7:0] FC_WRITE_COILS   = 8'h0F;
   localparam logic [7:0] FC_WRITE_REGS    = 8'h10;

   // ---------------------------------------------------------------
   // Printed table bases and register addresses
   // ---------------------------------------------------------------
   localparam logic [15:0] COIL_BASE            = 16'h0001;
   localparam logic [15:0] DI_BASE              = 16'h2711;
   localparam logic [15:0] IR_BASE              = 16'h7531;
   localparam logic [15:0] HR_BASE              = 16'h9C41;
   localparam logic [15:0] REG_COMMAND_COILS    = 16'h0001;
   localparam logic [15:0] REG_STATUS_DISCRETES = 16'h2711;
   localparam logic [15:0] REG_STATUS_INPUT     = 16'h7531;
   localparam logic [15:0] REG_STATUS_HOLDING   = 16'h9C41;
   localparam logic [15:0] REG_POS_FEEDBACK     = 16'h9D40;
   localparam logic [15:0] REG_COMMAND_WORD     = 16'h9E40;
   localparam logic [15:0] REG_BCAST_SHUTDOWN   = 16'h9E7F;
   localparam logic [15:0] REG_SETPOINT         = 16'h9E80;

   // Zero-based protocol offsets seen on the request port
   localparam logic [15:0] COIL_CMD_OFS    = REG_COMMAND_COILS - COIL_BASE;
   localparam logic [15:0] DI_STATUS_OFS   = REG_STATUS_DISCRETES - DI_BASE;
   localparam logic [15:0] IR_STATUS_OFS   = REG_STATUS_INPUT - IR_BASE;
   localparam logic [15:0] HR_STATUS_OFS   = REG_STATUS_HOLDING - HR_BASE;
   localparam logic [15:0] HR_FEEDBACK_OFS = REG_POS_FEEDBACK - HR_BASE;
   localparam logic [15:0] HR_CMD_OFS      = REG_COMMAND_WORD - HR_BASE;
   localparam logic [15:0] HR_BCAST_OFS    = REG_BCAST_SHUTDOWN - HR_BASE;
   localparam logic [15:0] HR_SETPOINT_OFS = REG_SETPOINT - HR_BASE;

   // ---------------------------------------------------------------
   // Values and field positions
   // ---------------------------------------------------------------
   localparam logic [15:0] ESD_BCAST_ON    = 16'h0007;
   localparam logic [15:0] ESD_BCAST_OFF   = 16'h0000;
   localparam logic [15:0] COIL_ON         = 16'hFF00;
   localparam logic [15:0] COIL_OFF        = 16'h0000;
   localparam logic [15:0] POS_PCT_MAX     = 16'h0064;
   localparam logic [15:0] VALUE12_MAX     = 16'h0FFF;
   localparam logic [3:0]  PCT_TYPE_LIMIT  = 4'h2;
   localparam int          UNIT_ALARM_BIT  = 15;
   localparam int          ALARM_LO        = 6;
   localparam int          ALARM_HI        = 12;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      CMD_OPEN     = 2'b00,
      CMD_STOP     = 2'b01,
      CMD_CLOSE    = 2'b10,
      CMD_SHUTDOWN = 2'b11
   } valve_cmd_t;

   typedef struct packed {
      logic [7:0]  func;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        last;
   } req_t;

   typedef struct packed {
      logic        err;
      logic [15:0] rdata;
   } rsp_t;

   typedef struct packed {
      logic [7:0]  valve;
      logic [3:0]  dev_type;
      logic [15:0] status;
      logic [15:0] position;
   } upd_t;

   typedef struct packed {
      logic [7:0]  valve;
      logic        positioning;
      valve_cmd_t  cmd;
      logic [15:0] setpoint;
   } fcmd_t;

endpackage

// [logic/valve_network_modbus_map.sv]
// Valve network register map: host access port, per-valve tables and field dispatch
`timescale 1ns/1ps

// What this block does
// RULE_01: Function 02 reads sixteen status bits per valve, valve n at 16(n-1).
// RULE_02: Function 03 reads each valve status word at holding offset n-1.
// RULE_03: Function 04 reads the same status word at input offset n-1.
// RULE_04: Position feedback holding registers follow network order from offset 255.
// RULE_05: Setpoint readback holding registers follow network order from offset 575.
// RULE_06: Types 0 and 1 return position as percent, 0 to 100.
// RULE_07: Other types return 12-bit position and setpoint, 0 to 4095.
// RULE_08: Four command coils per valve: open, stop, close, emergency shutdown.
// RULE_09: Command words from offset 511 hold four commands for four valves.
// RULE_10: Sixty-three command words; the last one ends at valve 250.
// RULE_11: Writing 7 to the broadcast word starts emergency shutdown to all.
// RULE_12: Writing 0 to the broadcast word ends the broadcast shutdown.
// RULE_13: Zero command bits cause no action.
// RULE_14: A set command coil clears itself once the actuator executed it.
// RULE_15: Host sets at most one command coil per valve at a time.
// RULE_16: Several command bits for one valve in one write are discarded.
// RULE_17: Shutdown goes to the actuator, which applies its own configured reaction.
// RULE_18: Setpoints 0 to 4095 for types above 1 are forwarded to the valve.
// RULE_19: Actuator mode follows command kind: discrete or positioning.
// RULE_20: Unit alarm bit is set when any of alarm bits 6 to 12 is set.
// RULE_21: Requests carry zero-based offsets: printed address minus table base.
module valve_network_modbus_map
   import valve_map_pkg::*;
(
   // Clock and reset
   input  wire logic CLOCK,
   input  wire logic RESET_N,
   // Host request and answer
   input  wire logic REQ_VALID,
   input  wire req_t REQ,
   output logic      RSP_VALID,
   output rsp_t      RSP,
   // Field status updates
   input  wire logic FIELD_UPD_VALID,
   input  wire upd_t FIELD_UPD,
   // Field command dispatch
   output logic      FIELD_CMD_VALID,
   input  wire logic FIELD_CMD_READY,
   output fcmd_t     FIELD_CMD,
   output logic      BCAST_ESD
);

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n_sync;

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta_reg <= 1'b0;
         rst_n_sync   <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_sync   <= rst_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // Per-valve tables
   // ---------------------------------------------------------------
   logic [15:0]           status_mem [0:NUM_VALVES-1];
   logic [15:0]           pos_mem    [0:NUM_VALVES-1];
   logic [15:0]           sp_mem     [0:NUM_VALVES-1];
   logic [3:0]            type_mem   [0:NUM_VALVES-1];
   logic [1:0]            code_mem   [0:NUM_VALVES-1];
   logic [NUM_VALVES-1:0] disc_pend_reg;
   logic [NUM_VALVES-1:0] sp_pend_reg;

   function automatic logic [15:0] scaled_view(input logic [3:0] dtype, input logic [15:0] value);
      if (dtype < PCT_TYPE_LIMIT)
         scaled_view = (value > POS_PCT_MAX) ? POS_PCT_MAX : value;
      else
         scaled_view = value & VALUE12_MAX;
   endfunction

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   wire logic [7:0]  fc       = REQ.func;
   wire logic [15:0] di_rel   = REQ.addr - DI_STATUS_OFS;
   wire logic [15:0] hs_rel   = REQ.addr - HR_STATUS_OFS;
   wire logic [15:0] ir_rel   = REQ.addr - IR_STATUS_OFS;
   wire logic [15:0] fb_rel   = REQ.addr - HR_FEEDBACK_OFS;
   wire logic [15:0] sp_rel   = REQ.addr - HR_SETPOINT_OFS;
   wire logic [15:0] cmd_rel  = REQ.addr - HR_CMD_OFS;
   wire logic [15:0] coil_rel = REQ.addr - COIL_CMD_OFS;

   wire logic in_di     = REQ.addr >= DI_STATUS_OFS && di_rel < DI_COUNT;          // RULE_01
   wire logic in_hs     = REQ.addr >= HR_STATUS_OFS && hs_rel < VALVE_COUNT;       // RULE_02
   wire logic in_ir     = REQ.addr >= IR_STATUS_OFS && ir_rel < VALVE_COUNT;       // RULE_03
   wire logic in_fb     = REQ.addr >= HR_FEEDBACK_OFS && fb_rel < VALVE_COUNT;     // RULE_04
   wire logic in_sp     = REQ.addr >= HR_SETPOINT_OFS && sp_rel < VALVE_COUNT;     // RULE_05
   wire logic in_cmd    = REQ.addr >= HR_CMD_OFS && cmd_rel < CMD_WORDS;           // RULE_10
   wire logic in_coil   = REQ.addr >= COIL_CMD_OFS && coil_rel < COIL_COUNT;       // RULE_21
   wire logic is_bcast  = REQ.addr == HR_BCAST_OFS;

   wire logic [7:0] di_valve   = di_rel[11:4];
   wire logic [7:0] coil_valve = coil_rel[9:2];                                  // RULE_08
   wire logic [7:0] sp_valve   = sp_rel[7:0];

   wire logic is_single_coil = fc == FC_WRITE_COIL;
   wire logic is_multi_coil  = fc == FC_WRITE_COILS;
   wire logic is_reg_write   = fc == FC_WRITE_REG || fc == FC_WRITE_REGS;
   wire logic coil_value_ok  = !is_single_coil || REQ.wdata == COIL_ON || REQ.wdata == COIL_OFF;
   wire logic coil_on        = is_single_coil ? (REQ.wdata == COIL_ON) : REQ.wdata[0];
   wire logic sp_ok          = type_mem[sp_valve] >= PCT_TYPE_LIMIT && REQ.wdata <= VALUE12_MAX; // RULE_18

   wire logic ok_rd_di = fc == FC_READ_DISCRETE && in_di;
   wire logic ok_rd_hr = fc == FC_READ_HOLDING && (in_hs || in_fb || in_sp);
   wire logic ok_rd_ir = fc == FC_READ_INPUT && in_ir;
   wire logic ok_coil  = (is_single_coil || is_multi_coil) && in_coil && coil_value_ok;
   wire logic ok_reg   = is_reg_write && (in_cmd || is_bcast || (in_sp && sp_ok));
   wire logic req_ok   = ok_rd_di || ok_rd_hr || ok_rd_ir || ok_coil || ok_reg;

   wire logic wr_coil     = REQ_VALID && ok_coil;
   wire logic wr_cmd_word = REQ_VALID && ok_reg && in_cmd;                          // RULE_09
   wire logic wr_setpoint = REQ_VALID && ok_reg && in_sp;                           // RULE_18
   wire logic wr_bcast    = REQ_VALID && ok_reg && is_bcast;

   // ---------------------------------------------------------------
   // Read data selection
   // ---------------------------------------------------------------
   wire logic [15:0] di_word  = status_mem[di_valve];
   wire logic [15:0] rd_di    = {15'h0000, di_word[di_rel[3:0]]};                   // RULE_01
   wire logic [15:0] rd_fb    = scaled_view(type_mem[fb_rel[7:0]], pos_mem[fb_rel[7:0]]); // RULE_06 RULE_07
   wire logic [15:0] rd_sp    = scaled_view(type_mem[sp_valve], sp_mem[sp_valve]);  // RULE_07
   wire logic [15:0] rd_hr    = in_hs ? status_mem[hs_rel[7:0]] : (in_fb ? rd_fb : rd_sp); // RULE_02
   wire logic [15:0] rd_data  = ok_rd_di ? rd_di :
                                ok_rd_ir ? status_mem[ir_rel[7:0]] :                // RULE_03
                                ok_rd_hr ? rd_hr : 16'h0000;

   // ---------------------------------------------------------------
   // Command coil gathering
   // ---------------------------------------------------------------
   // A multiple-coil write arrives one coil per request, so the bits of one
   // valve are gathered until the valve changes or the frame ends.
   logic       acc_live_reg;
   logic [7:0] acc_valve_reg;
   logic [3:0] acc_bits_reg;

   wire logic [3:0] coil_bit  = coil_on ? (4'h1 << coil_rel[1:0]) : 4'h0;          // RULE_08 RULE_13
   wire logic       acc_same  = acc_live_reg && acc_valve_reg == coil_valve;
   wire logic [3:0] merged    = (acc_same ? acc_bits_reg : 4'h0) | coil_bit;
   wire logic       flush_acc = wr_coil && is_multi_coil && acc_live_reg && !acc_same;

   logic [7:0] slot_valve [4];
   logic [3:0] slot_bits  [4];
   logic [1:0] slot_code  [4];
   logic       slot_go    [4];
   logic       set_same;
   logic       fire;

   always_comb begin
      set_same = 1'b0;
      for (int j = 0; j < 4; j++) begin
         slot_valve[j] = coil_valve;
         slot_bits[j]  = 4'h0;
         if (wr_cmd_word) begin
            slot_valve[j] = {cmd_rel[5:0], 2'(j)};                                  // RULE_09
            slot_bits[j]  = (slot_valve[j] <= VALVE_LAST) ? REQ.wdata[4*j +: 4] : 4'h0; // RULE_10
         end else if (j == 0 && flush_acc) begin
            slot_valve[j] = acc_valve_reg;
            slot_bits[j]  = acc_bits_reg;
         end else if (j == 1 && wr_coil && (is_single_coil || REQ.last)) begin
            slot_bits[j]  = is_single_coil ? coil_bit : merged;
         end
         // Zero bits do nothing and two or more bits are a no-op
         slot_go[j]   = slot_bits[j] != 4'h0 && (slot_bits[j] & (slot_bits[j] - 4'h1)) == 4'h0; // RULE_13 RULE_16
         slot_code[j] = slot_bits[j][1] ? 2'd1 : (slot_bits[j][2] ? 2'd2 : (slot_bits[j][3] ? 2'd3 : 2'd0));
         if (slot_go[j] && slot_valve[j] == FIELD_CMD.valve)
            set_same = 1'b1;
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         acc_live_reg  <= 1'b0;
         acc_valve_reg <= 8'h00;
         acc_bits_reg  <= 4'h0;
      end else if (wr_coil && is_multi_coil) begin
         acc_live_reg  <= !REQ.last;
         acc_valve_reg <= coil_valve;
         acc_bits_reg  <= merged;
      end
   end

   // ---------------------------------------------------------------
   // Table storage
   // ---------------------------------------------------------------
   wire logic upd_ok = FIELD_UPD_VALID && FIELD_UPD.valve <= VALVE_LAST;

   always_ff @(posedge CLOCK) begin
      if (upd_ok) begin
         status_mem[FIELD_UPD.valve] <= {|FIELD_UPD.status[ALARM_HI:ALARM_LO], FIELD_UPD.status[14:0]}; // RULE_20
         pos_mem[FIELD_UPD.valve]    <= FIELD_UPD.position;
         type_mem[FIELD_UPD.valve]   <= FIELD_UPD.dev_type;
      end
      if (wr_setpoint)
         sp_mem[sp_valve] <= REQ.wdata;
      for (int j = 0; j < 4; j++) begin
         if (slot_go[j])
            code_mem[slot_valve[j]] <= slot_code[j];
      end
   end

   // A new command for the valve being dispatched wins over its clear
   always_ff @(posedge CLOCK or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         disc_pend_reg <= '0;
         sp_pend_reg   <= '0;
      end else begin
         if (fire && !FIELD_CMD.positioning)
            disc_pend_reg[FIELD_CMD.valve] <= 1'b0;                                 // RULE_14
         if (fire && FIELD_CMD.positioning)
            sp_pend_reg[FIELD_CMD.valve] <= 1'b0;
         for (int j = 0; j < 4; j++) begin
            if (slot_go[j])
               disc_pend_reg[slot_valve[j]] <= 1'b1;                               // RULE_08
         end
         if (wr_setpoint)
            sp_pend_reg[sp_valve] <= 1'b1;                                          // RULE_18
      end
   end

   // ---------------------------------------------------------------
   // Answers and broadcast shutdown
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         RSP_VALID <= 1'b0;
         RSP       <= '0;
         BCAST_ESD <= 1'b0;
      end else begin
         RSP_VALID <= REQ_VALID;
         if (REQ_VALID) begin
            RSP.err   <= !req_ok;
            RSP.rdata <= rd_data;
         end
         // Any other value leaves the broadcast as it stands
         if (wr_bcast && REQ.wdata == ESD_BCAST_ON)
            BCAST_ESD <= 1'b1;                                                      // RULE_11
         else if (wr_bcast && REQ.wdata == ESD_BCAST_OFF)
            BCAST_ESD <= 1'b0;                                                      // RULE_12
      end
   end

   // ---------------------------------------------------------------
   // Field dispatch
   // ---------------------------------------------------------------
   // One valve at a time; on one valve discrete commands go before setpoints, and a pass over
   // all valves bounds how long a discrete command waits; a setpoint behind one on its valve waits for the next pass.
   typedef enum logic [0:0] {
      DSP_SCAN  = 1'b0,
      DSP_ISSUE = 1'b1
   } dsp_state_t;

   dsp_state_t state_reg;
   logic [7:0] scan_reg;

   wire logic [7:0] scan_next = (scan_reg == VALVE_LAST) ? 8'h00 : scan_reg + 8'h01;
   wire logic       scan_hit  = disc_pend_reg[scan_reg] || sp_pend_reg[scan_reg];

   assign FIELD_CMD_VALID = state_reg == DSP_ISSUE;
   assign fire            = FIELD_CMD_VALID && FIELD_CMD_READY;

   always_ff @(posedge CLOCK or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         state_reg <= DSP_SCAN;
         scan_reg  <= 8'h00;
         FIELD_CMD <= '0;
      end else begin
         case (state_reg)
            DSP_SCAN: begin
               if (scan_hit) begin
                  FIELD_CMD.valve       <= scan_reg;
                  FIELD_CMD.positioning <= !disc_pend_reg[scan_reg];                // RULE_19
                  FIELD_CMD.cmd         <= valve_cmd_t'(code_mem[scan_reg]);        // RULE_17
                  FIELD_CMD.setpoint    <= sp_mem[scan_reg];
                  state_reg             <= DSP_ISSUE;
               end else begin
                  scan_reg <= scan_next;
               end
            end
            DSP_ISSUE: begin
               if (FIELD_CMD_READY) begin
                  scan_reg  <= scan_next;
                  state_reg <= DSP_SCAN;
               end
            end
            default: state_reg <= DSP_SCAN;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!rst_n_sync);

   chk_di_range: assert property (REQ_VALID && fc == FC_READ_DISCRETE && !in_di |=> RSP_VALID && RSP.err) // RULE_01
      else $error("discrete read beyond valve 250 accepted");
   chk_ir_word: assert property (REQ_VALID && ok_rd_ir |=> RSP.rdata == $past(status_mem[ir_rel[7:0]])) // RULE_03
      else $error("input register status word mismatch");
   chk_unit_alarm: assert property (upd_ok |=> status_mem[$past(FIELD_UPD.valve)][UNIT_ALARM_BIT] == // RULE_20
                                    $past(|FIELD_UPD.status[ALARM_HI:ALARM_LO]))
      else $error("unit alarm bit does not follow alarm bits");
   chk_pct_limit: assert property (REQ_VALID && fc == FC_READ_HOLDING && in_fb && !in_hs && // RULE_06
                                   type_mem[fb_rel[7:0]] < PCT_TYPE_LIMIT |=> RSP.rdata <= POS_PCT_MAX)
      else $error("percent position above 100");
   chk_sp_reject: assert property (REQ_VALID && is_reg_write && in_sp && REQ.wdata > VALUE12_MAX // RULE_18
                                   |=> RSP.err && !sp_pend_reg[$past(sp_valve)] || $past(sp_pend_reg[sp_valve]))
      else $error("out of range setpoint accepted");
   chk_bcast_on: assert property (wr_bcast && REQ.wdata == ESD_BCAST_ON |=> BCAST_ESD ##1 // RULE_11
                                  (BCAST_ESD || $past(wr_bcast && REQ.wdata == ESD_BCAST_OFF)))
      else $error("broadcast shutdown did not start");
   chk_bcast_off: assert property (wr_bcast && REQ.wdata == ESD_BCAST_OFF |=> !BCAST_ESD) // RULE_12
      else $error("broadcast shutdown did not end");
   chk_coil_zero: assert property (wr_coil && is_single_coil && !coil_on && !disc_pend_reg[coil_valve] // RULE_13
                                   |=> !disc_pend_reg[$past(coil_valve)])
      else $error("zero coil caused a command");
   chk_coil_set: assert property (wr_coil && is_single_coil && coil_on |=> disc_pend_reg[$past(coil_valve)] && // RULE_08
                                  code_mem[$past(coil_valve)] == $past(coil_rel[1:0]))
      else $error("coil write did not post its command");
   chk_multi_drop: assert property (wr_cmd_word && REQ.wdata[1:0] == 2'b11 && !disc_pend_reg[slot_valve[0]] && // RULE_16
                                    !(fire && FIELD_CMD.valve == slot_valve[0]) |=> !disc_pend_reg[$past(slot_valve[0])])
      else $error("several bits for one valve not discarded");
   chk_exec_clear: assert property (fire && !FIELD_CMD.positioning && !set_same // RULE_14
                                    |=> !disc_pend_reg[$past(FIELD_CMD.valve)] && !FIELD_CMD_VALID)
      else $error("executed command not cleared");
   chk_dispatch_hold: assert property (FIELD_CMD_VALID && !FIELD_CMD_READY |=> FIELD_CMD_VALID && $stable(FIELD_CMD)) // RULE_19
      else $error("field command changed before accepted");

   cov_coil_cmd:   cover property (wr_coil && is_single_coil && coil_on ##[1:600] fire);
   cov_word_cmd:   cover property (wr_cmd_word && slot_go[3]);
   cov_setpoint:   cover property (wr_setpoint ##[1:600] fire && FIELD_CMD.positioning);
   cov_bcast:      cover property (BCAST_ESD ##[1:50] !BCAST_ESD);

endmodule

// [testbench/actuator_stub.sv]
// Field actuator stand-in that executes commands promptly or slowly
`timescale 1ns/1ps
module actuator_stub (
   // Clock and dispatch
   input  wire logic clk,
   input  wire logic cmd_valid,
   input  wire logic slow,
   output logic      cmd_ready
);
   logic [2:0] wait_reg;
   initial wait_reg = 3'h0;
   always @(posedge clk) begin
      wait_reg <= (cmd_valid && !cmd_ready) ? wait_reg + 3'h1 : 3'h0;
   end
   // Executes at once, or after four waiting cycles when slow is set
   assign cmd_ready = cmd_valid && (wait_reg >= (slow ? 3'h4 : 3'h0));
endmodule

// [testbench/valve_network_modbus_map_tb.sv]
// Bench for the valve map: host reads and writes, field traffic
`timescale 1ns/1ps
module valve_network_modbus_map_tb;
   import valve_map_pkg::*;
   logic        clk, rst_n, rv, fuv, fcv, fcr, emergency_shutdown, rspv, slow;
   req_t        r;
   rsp_t        rsp;
   upd_t        fu;
   fcmd_t       fc;
   logic [17:0] rq[$];
   logic [24:0] fq[$];
   logic [15:0] x = 16'h9B7E;
   logic [15:0] s, p, sp;
   logic [7:0]  v;
   logic        lst = 1'b1;
   int          miscompares, total_checks, i;
   valve_network_modbus_map valve_network_modbus_map_inst (.CLOCK(clk), .RESET_N(rst_n), .REQ_VALID(rv),
      .REQ(r), .RSP_VALID(rspv), .RSP(rsp), .FIELD_UPD_VALID(fuv), .FIELD_UPD(fu),
      .FIELD_CMD_VALID(fcv), .FIELD_CMD_READY(fcr), .FIELD_CMD(fc), .BCAST_ESD(emergency_shutdown));
   actuator_stub actuator_stub_inst (.clk(clk), .cmd_valid(fcv), .slow(slow), .cmd_ready(fcr));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [15:0] rnd();
      x ^= x << 7;
      x ^= x >> 9;
      x ^= x << 8;
      return x;
   endfunction
   task automatic chk(input logic [24:0] a, e);
      total_checks++;
      if (a !== e) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, a, e);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Error bit always compared; data only when the note asks for it
   task automatic chk_rsp(input logic [17:0] e);
      chk(25'(rsp & (e[17] ? 17'h1FFFF : 17'h10000)), 25'(e[16:0] & (e[17] ? 17'h1FFFF : 17'h10000)));
   endtask
   task automatic req(input logic [7:0] f, input logic [15:0] a, d, e, input logic er, full);
      @(posedge clk);
      #1;
      rv = 1'b1;
      r = '{f, a, d, lst};
      rq.push_back({full, er, e});
      @(posedge clk);
      #1;
      rv = 1'b0;
   endtask
   task automatic upd(input logic [7:0] n, input logic [3:0] t);
      @(posedge clk);
      #1;
      s = rnd();
      p = rnd();
      fuv = 1'b1;
      fu = '{n, t, s, p};
      @(posedge clk);
      #1;
      fuv = 1'b0;
   endtask
   task automatic drain();
      for (i = 0; i < 600 && fq.size() != 0; i++) @(posedge clk);
      chk(25'(fq.size()), 25'h0);
   endtask
   always @(posedge clk) begin
      if (rspv === 1'b1) chk_rsp(rq.pop_front());
      if (fcv === 1'b1 && fcr === 1'b1) chk({fc.valve, fc.positioning, fc.positioning ? fc.setpoint : {14'h0, fc.cmd}}, fq.pop_front());
   end
   initial begin
      #800000;
      miscompares++;
      conclude();
   end
   initial begin
      rst_n = 1'b0; rv = 1'b0; fuv = 1'b0; slow = 1'b0; r = '0; fu = '0;
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk);
      for (int k = 0; k < 3; k++) begin
         v = k == 0 ? 8'h00 : (k == 1 ? VALVE_LAST : 8'h05);
         upd(v, k == 2 ? 4'h1 : 4'(k + 2));
         req(FC_READ_HOLDING, 16'(v), 16'h0, {|s[12:6], s[14:0]}, 1'b0, 1'b1);
         req(FC_READ_INPUT, 16'(v), 16'h0, {|s[12:6], s[14:0]}, 1'b0, 1'b1);
         req(FC_READ_DISCRETE, {4'h0, v, 4'hF}, 16'h0, {15'h0, |s[12:6]}, 1'b0, 1'b1);
         req(FC_READ_DISCRETE, {4'h0, v, 4'h3}, 16'h0, {15'h0, s[3]}, 1'b0, 1'b1);
         req(FC_READ_HOLDING, HR_FEEDBACK_OFS + 16'(v), 16'h0, k == 2 ? (p > POS_PCT_MAX ? POS_PCT_MAX : p)
             : p & VALUE12_MAX, 1'b0, 1'b1);
      end
      sp = rnd() & VALUE12_MAX;
      fq.push_back({8'h00, 1'b1, sp});
      req(FC_WRITE_REGS, HR_SETPOINT_OFS, sp, 16'h0, 1'b0, 1'b0);
      req(FC_READ_HOLDING, HR_SETPOINT_OFS, 16'h0, sp, 1'b0, 1'b1);
      drain();
      req(FC_WRITE_REG, HR_SETPOINT_OFS + 16'h0005, sp, 16'h0, 1'b1, 1'b0);
      req(FC_WRITE_REG, HR_SETPOINT_OFS, 16'h1000, 16'h0, 1'b1, 1'b0);
      req(FC_READ_HOLDING, 16'h0400, 16'h0, 16'h0, 1'b1, 1'b0);
      req(8'h01, 16'h0, 16'h0, 16'h0, 1'b1, 1'b0);
      req(FC_READ_DISCRETE, DI_COUNT, 16'h0, 16'h0, 1'b1, 1'b0);
      for (int c = 0; c < 4; c++) begin
         slow = c[0];
         fq.push_back({VALVE_LAST, 1'b0, 16'(c)});
         req(FC_WRITE_COIL, {6'h0, VALVE_LAST, 2'(c)}, COIL_ON, 16'h0, 1'b0, 1'b0);
         drain();
         req(FC_WRITE_COIL, {6'h0, VALVE_LAST, 2'(c)}, COIL_OFF, 16'h0, 1'b0, 1'b0);
      end
      // Multiple-coil frame: one coil per request, only the stop coil set
      fq.push_back({VALVE_LAST, 1'b0, 16'(CMD_STOP)});
      for (int c = 0; c < 4; c++) begin
         lst = c == 3;
         req(FC_WRITE_COILS, {6'h0, VALVE_LAST, 2'(c)}, 16'(c == 1), 16'h0, 1'b0, 1'b0);
      end
      lst = 1'b1;
      drain();
      fq.push_back({VALVE_LAST, 1'b0, 16'(CMD_OPEN)});
      req(FC_WRITE_REG, HR_CMD_OFS + 16'h003E, 16'h1113, 16'h0, 1'b0, 1'b0);
      drain();
      req(FC_WRITE_REG, HR_BCAST_OFS, ESD_BCAST_ON, 16'h0, 1'b0, 1'b0);
      chk(25'(emergency_shutdown), 25'h1);
      req(FC_WRITE_REG, HR_BCAST_OFS, ESD_BCAST_OFF, 16'h0, 1'b0, 1'b0);
      chk(25'(emergency_shutdown), 25'h0);
      // Let the last answer reach the monitor before the verdict
      repeat (2) @(posedge clk);
      chk(25'(rq.size()), 25'h0);
      conclude();
   end
endmodule
